//--- std_irq_regs.svh
// Purpose: register indices, field positions and reset values of the irq channel bank
// Assumes: byte address of a register is four times its index
// Notes: channels 0..7 are E0,E1,F0,F1,G0,G1,H0,H1; channel 8 is I0
`ifndef STD_IRQ_REGS_SVH
`define STD_IRQ_REGS_SVH

`define IDX_EVT_STATUS 8'hf0
`define IDX_EVT_MASK   8'hf1
`define IDX_I_MASK     8'hf5
`define IDX_EH_MASK    8'hf6
`define IDX_I_EDGE     8'hf7
`define IDX_EH_EDGE    8'hf8
`define IDX_I_PEND     8'hf9
`define IDX_EH_PEND    8'hfa
`define IDX_VECTOR     8'hfb
`define IDX_I_PRIO     8'hfc
`define IDX_EH_PRIO    8'hfd
`define IDX_I_OVR      8'hfe
`define IDX_EH_OVR     8'hff

`define VEC_HI_LSB     5
`define WIN_LSB        1
`define CHAN_I         4'h8
`define WIN_NONE       4'hf

`define RST_EH_PRIO    8'hff
`define RST_I_PRIO     2'h3
`define RST_OVR        9'h000
`define RST_WINNER     4'hf
`define LEVEL_LOWEST   3'h7

`endif

//--- std_irq_pkg.sv
// Purpose: types and priority helper of the irq channel bank
// Assumes: nine channels, index 8 is I0
// Notes: chan_level shared by the arbiter and the bank checks
package std_irq_pkg;

  typedef logic [8:0] chan_vec_t;
  typedef logic [2:0] level_t;

  typedef struct packed {
    chan_vec_t   mask;
    chan_vec_t   edge_sel;
    chan_vec_t   pend;
    chan_vec_t   ovr;
    logic [7:0]  prio_eh;
    logic [1:0]  prio_i;
    logic [2:0]  vec_hi;
    logic [3:0]  winner;
    logic [1:0]  evt_stat;
    logic [1:0]  evt_mask;
    logic [31:0] rdata;
  } bank_state_t;

  // pair field on top, channel parity as lsb
  function automatic level_t chan_level(input logic [3:0] ch,
                                        input logic [7:0] prio_eh,
                                        input logic [1:0] prio_i);
    logic [1:0] upper;
    upper = prio_i;
    if (ch < 4'h8) begin
      upper = prio_eh[{ch[2:1], 1'b0} +: 2];
    end
    return {upper, ch[0]};
  endfunction

endpackage

//--- line_edge_detect.sv
// Purpose: synchronise interrupt lines and flag their edges
// Assumes: lines are asynchronous to pclk
// Notes: edges are ignored until the synchroniser has filled after reset
`timescale 1ns/10ps
module line_edge_detect #(
  parameter int N = 9
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // lines
  input  wire logic [N-1:0] line_in,
  // edge pulses
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prev;
    logic [1:0]   fill;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d      = q;
    d.s1   = line_in;
    d.s2   = q.s1;
    d.prev = q.s2;
    if (q.fill != 2'h3) begin
      d.fill = q.fill + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // no edge until prev holds a real sample
  assign rise = (q.fill == 2'h3) ? (q.s2 & ~q.prev) : '0;
  assign fall = (q.fill == 2'h3) ? (~q.s2 & q.prev) : '0;

endmodule // line_edge_detect

//--- chan_priority_arbiter.sv
// Purpose: pick the most urgent requesting channel
// Assumes: req already gated by mask
// Notes: strict compare keeps the lower index on a tie
`timescale 1ns/10ps
`include "std_irq_regs.svh"
module chan_priority_arbiter import std_irq_pkg::*; #(
  parameter int NCH = 9
) (
  // requests and priority fields
  input  wire logic [NCH-1:0] req,
  input  wire logic [7:0]     prio_eh,
  input  wire logic [1:0]     prio_i,
  // winner
  output logic                valid,
  output logic      [3:0]     win_idx,
  output level_t              win_level
);

  level_t lvl;

  always_comb begin
    valid     = 1'b0;
    win_idx   = `WIN_NONE;
    win_level = `LEVEL_LOWEST;
    lvl       = `LEVEL_LOWEST;
    for (int i = 0; i < NCH; i++) begin
      lvl = chan_level(4'(i), prio_eh, prio_i);
      if (req[i] && (!valid || lvl < win_level)) begin
        valid     = 1'b1;
        win_idx   = 4'(i);
        win_level = lvl;
      end
    end
  end

endmodule // chan_priority_arbiter

//--- std_irq_channel_bank.sv
// Purpose: register bank of the standard interrupt channels E0..H1 and I0
// Assumes: apb slave with zero wait states; lines asynchronous to pclk
// Notes: irq_ack clears the pending bit of the latched winner
`timescale 1ns/10ps
`include "std_irq_regs.svh"
module std_irq_channel_bank import std_irq_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt lines
  input  wire logic [8:0]  line_in,
  // cpu arbitration
  input  wire logic        arb_start,
  input  wire logic        irq_ack,
  output logic             cpu_req,
  output logic      [2:0]  cpu_req_level,
  output logic      [3:0]  winner_code,
  // event interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  bank_state_t q;
  bank_state_t d;

  chan_vec_t  rise;
  chan_vec_t  fall;
  chan_vec_t  hw_evt;
  chan_vec_t  ack_clr;
  chan_vec_t  base_pend;
  chan_vec_t  cleared;
  chan_vec_t  new_ovr;
  logic       apb_setup;
  logic       apb_wr;
  logic [7:0] acc_idx;
  logic       acc_hit;
  logic       edge_wr;
  logic       arb_valid;
  logic [3:0] arb_idx;
  level_t     arb_level;

  // aligned word inside the page that maps a register
  function automatic logic decode(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    return (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
           ((idx >= `IDX_I_MASK) || (idx == `IDX_EVT_STATUS) ||
            (idx == `IDX_EVT_MASK));
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] idx, input bank_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IDX_EVT_STATUS: v = {6'h00, s.evt_stat};
      `IDX_EVT_MASK:   v = {6'h00, s.evt_mask};
      `IDX_I_MASK:     v = {7'h00, s.mask[8]};
      `IDX_EH_MASK:    v = s.mask[7:0];
      `IDX_I_EDGE:     v = {7'h00, s.edge_sel[8]};
      `IDX_EH_EDGE:    v = s.edge_sel[7:0];
      `IDX_I_PEND:     v = {7'h00, s.pend[8]};
      `IDX_EH_PEND:    v = s.pend[7:0];
      `IDX_VECTOR:     v = {s.vec_hi, s.winner, 1'b0};
      `IDX_I_PRIO:     v = {6'h00, s.prio_i};
      `IDX_EH_PRIO:    v = s.prio_eh;
      `IDX_I_OVR:      v = {7'h00, s.ovr[8]};
      `IDX_EH_OVR:     v = s.ovr[7:0];
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // line edges and arbitration

  line_edge_detect #(
    .N (9)
  ) u_edges (
    .pclk    (pclk),
    .presetn (presetn),
    .line_in (line_in),
    .rise    (rise),
    .fall    (fall)
  );

  chan_priority_arbiter #(
    .NCH (9)
  ) u_arb (
    .req       (q.pend & q.mask),
    .prio_eh   (q.prio_eh),
    .prio_i    (q.prio_i),
    .valid     (arb_valid),
    .win_idx   (arb_idx),
    .win_level (arb_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign acc_idx   = paddr[9:2];
  assign acc_hit   = decode(paddr);

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    // edge select being written masks trigger edges that cycle
    edge_wr = apb_wr && acc_hit && ((acc_idx == `IDX_I_EDGE) || (acc_idx == `IDX_EH_EDGE));
    hw_evt  = edge_wr ? '0 : ((q.edge_sel & rise) | (~q.edge_sel & fall));
    ack_clr = '0;
    if (irq_ack && (q.winner <= `CHAN_I)) begin
      ack_clr[q.winner] = 1'b1;
    end
    base_pend = q.pend & ~ack_clr;
    if (apb_wr && acc_hit) begin
      case (acc_idx)
        `IDX_EVT_STATUS: d.evt_stat       = q.evt_stat & ~pwdata[1:0];
        `IDX_EVT_MASK:   d.evt_mask       = pwdata[1:0];
        `IDX_I_MASK:     d.mask[8]        = pwdata[0];
        `IDX_EH_MASK:    d.mask[7:0]      = pwdata[7:0];
        `IDX_I_EDGE:     d.edge_sel[8]    = pwdata[0];
        `IDX_EH_EDGE:    d.edge_sel[7:0]  = pwdata[7:0];
        `IDX_I_PEND:     base_pend[8]     = pwdata[0];
        `IDX_EH_PEND:    base_pend[7:0]   = pwdata[7:0];
        `IDX_VECTOR:     d.vec_hi         = pwdata[`VEC_HI_LSB +: 3];
        `IDX_I_PRIO:     d.prio_i         = pwdata[1:0];
        `IDX_EH_PRIO:    d.prio_eh        = pwdata[7:0];
        default:         d.vec_hi         = q.vec_hi; // overrun regs ignore writes
      endcase
    end
    // hardware trigger wins over any clear in the same cycle
    cleared = q.pend & ~base_pend;
    d.pend  = base_pend | hw_evt;
    new_ovr = hw_evt & q.pend;
    d.ovr   = (q.ovr & ~cleared) | new_ovr;
    // winner held between arbitration starts
    if (arb_start) begin
      d.winner = arb_valid ? arb_idx : `WIN_NONE;
    end
    // sticky events: bit0 overrun, bit1 winner latched
    if (new_ovr != '0) begin
      d.evt_stat[0] = 1'b1;
    end
    if (arb_start && arb_valid) begin
      d.evt_stat[1] = 1'b1;
    end
    // read data captured in setup, presented in access
    if (apb_setup && !pwrite) begin
      d.rdata = acc_hit ? {24'h000000, read_reg(acc_idx, q)} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.prio_eh  <= `RST_EH_PRIO;
      q.prio_i   <= `RST_I_PRIO;
      q.ovr      <= `RST_OVR;
      q.winner   <= `RST_WINNER;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata        = q.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~acc_hit;
  assign cpu_req       = arb_valid;
  assign cpu_req_level = arb_level;
  assign winner_code   = q.winner;
  assign irq           = |(q.evt_stat & q.evt_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // any requester more urgent than the winner, or equal and lower numbered
  logic better_exists;
  always_comb begin
    better_exists = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (q.pend[i] && q.mask[i] && arb_valid) begin
        if ((chan_level(4'(i), q.prio_eh, q.prio_i) < arb_level) ||
            ((chan_level(4'(i), q.prio_eh, q.prio_i) == arb_level) &&
             (4'(i) < arb_idx))) begin
          better_exists = 1'b1;
        end
      end
    end
  end

  sequence s_latch;
    arb_start && arb_valid;
  endsequence

  sequence s_quiet2;
    (!arb_start) [*2];
  endsequence

  sequence s_read_prio_eh;
    psel && !penable && !pwrite && acc_hit && (acc_idx == `IDX_EH_PRIO);
  endsequence

  property p_lsb_parity;
    cpu_req |-> (cpu_req_level[0] == arb_idx[0]);
  endproperty
  a_lsb_parity: assert property (p_lsb_parity)
    else $error("winner level lsb does not match channel parity");

  property p_upper_field;
    cpu_req && (arb_idx < `CHAN_I) |->
      (cpu_req_level[2:1] == q.prio_eh[{arb_idx[2:1], 1'b0} +: 2]);
  endproperty
  a_upper_field: assert property (p_upper_field)
    else $error("winner level upper bits differ from pair field");

  property p_best_wins;
    !better_exists;
  endproperty
  a_best_wins: assert property (p_best_wins)
    else $error("a more urgent or lower numbered channel lost");

  property p_reset_values;
    !$past(presetn) |-> (q.prio_eh == 8'hff) && (q.ovr == 9'h000);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("priority or overrun reset value wrong");

  property p_overrun_set;
    (hw_evt & q.pend) != '0 |=> ((q.ovr & $past(hw_evt & q.pend)) == $past(hw_evt & q.pend));
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("trigger on a pending channel did not raise overrun");

  property p_overrun_ro;
    apb_wr && acc_hit && ((acc_idx == `IDX_I_OVR) || (acc_idx == `IDX_EH_OVR)) &&
      (new_ovr == '0) && (cleared == '0) |=> $stable(q.ovr);
  endproperty
  a_overrun_ro: assert property (p_overrun_ro)
    else $error("software write changed an overrun flag");

  property p_req_gated;
    cpu_req |-> q.mask[arb_idx] && q.pend[arb_idx];
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("cpu request without masked-in pending channel");

  property p_trigger_sets_pending;
    (hw_evt != '0) |=> ((q.pend & $past(hw_evt)) == $past(hw_evt));
  endproperty
  a_trigger_sets_pending: assert property (p_trigger_sets_pending)
    else $error("selected edge did not set pending");

  property p_ack_clears;
    irq_ack && (q.winner <= `CHAN_I) && (hw_evt == '0) && !(apb_wr && acc_hit) |=>
      !q.pend[$past(q.winner)];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge left the winner pending");

  property p_winner_hold;
    s_latch ##1 s_quiet2 |-> (winner_code == $past(arb_idx, 2));
  endproperty
  a_winner_hold: assert property (p_winner_hold)
    else $error("winner code not latched or not held");

  property p_overrun_clear;
    ((($past(q.pend) & ~q.pend) & q.ovr) == '0);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun survived the clearing of its pending bit");

  property p_read_prio;
    s_read_prio_eh |=> (prdata[7:0] == $past(q.prio_eh)) && (prdata[31:8] == 24'h000000);
  endproperty
  a_read_prio: assert property (p_read_prio)
    else $error("priority register read returned wrong data");

  property p_irq_level;
    (new_ovr != '0) && q.evt_mask[0] &&
      !(apb_wr && acc_hit && (acc_idx == `IDX_EVT_MASK)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked overrun event did not raise the interrupt");

  property p_edge_write_drops;
    edge_wr |=> ((q.pend & ~$past(q.pend)) == '0);
  endproperty
  a_edge_write_drops: assert property (p_edge_write_drops)
    else $error("line edge during edge select write set a pending bit");

  property p_pend_write;
    apb_wr && acc_hit && (acc_idx == `IDX_EH_PEND) |=>
      ((q.pend[7:0] | $past(hw_evt[7:0])) == ($past(pwdata[7:0]) | $past(hw_evt[7:0])));
  endproperty
  a_pend_write: assert property (p_pend_write)
    else $error("software write to pending not stored");

  property p_winner_code;
    (winner_code <= `CHAN_I) || (winner_code == `WIN_NONE);
  endproperty
  a_winner_code: assert property (p_winner_code)
    else $error("winner code outside the channel encoding");

  property p_read_ovr;
    psel && !penable && !pwrite && acc_hit && (acc_idx == `IDX_EH_OVR) |=>
      (prdata == {24'h000000, $past(q.ovr[7:0])});
  endproperty
  a_read_ovr: assert property (p_read_ovr)
    else $error("overrun register read returned wrong data");

  property p_event_sticky;
    q.evt_stat[1] && !(apb_wr && acc_hit && (acc_idx == `IDX_EVT_STATUS) && pwdata[1]) |=>
      q.evt_stat[1];
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("latched event flag cleared without a one written");

endmodule // std_irq_channel_bank

//--- cpu_arb_model.sv
// Purpose: cpu arbitration side and interrupt line sources of the channel bank
// Assumes: everything changes just after a rising pclk edge
// Notes: pulses last one pclk cycle
`timescale 1ns/10ps
module cpu_arb_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // interrupt lines
  output logic      [8:0] line_in,
  // arbitration handshake
  output logic            arb_start,
  output logic            irq_ack
);
  initial begin
    line_in   = 9'h000;
    arb_start = 1'b0;
    irq_ack   = 1'b0;
  end

  // one line edge, then time for sync and pending update
  task automatic flip(input int ch);
    @(posedge pclk);
    line_in[ch] <= ~line_in[ch];
    repeat (6) @(posedge pclk);
  endtask

  task automatic arbitrate();
    @(posedge pclk);
    arb_start <= 1'b1;
    @(posedge pclk);
    arb_start <= 1'b0;
  endtask

  task automatic acknowledge();
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
  endtask
endmodule // cpu_arb_model

//--- tb_std_irq_channel_bank.sv
// Purpose: self-checking bench of the irq channel bank
// Assumes: apb master waits for pready; byte address is four times the index
// Notes: line edges need three cycles to reach pending
`timescale 1ns/10ps
`include "std_irq_regs.svh"
module tb_std_irq_channel_bank;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [8:0]  line_in;
  logic        arb_start;
  logic        irq_ack;
  logic        cpu_req;
  logic [2:0]  cpu_req_level;
  logic [3:0]  winner_code;
  logic        irq;
  logic [7:0]  rd;
  logic        er;
  int          err_count;
  int          check_count;

  std_irq_channel_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .arb_start(arb_start), .irq_ack(irq_ack), .cpu_req(cpu_req),
    .cpu_req_level(cpu_req_level), .winner_code(winner_code), .irq(irq));

  cpu_arb_model M (.pclk(pclk), .presetn(presetn), .line_in(line_in),
    .arb_start(arb_start), .irq_ack(irq_ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wdv,
                     output logic [7:0] rdv, output logic erv);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wdv;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata[7:0];
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      $display("Error at %0t: no pready", $time);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, {~d, d, ~d, d}, rd, er);
  endtask

  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h00000000, rd, er);
    chk_val(rd, exp);
  endtask

  task automatic chk_win(input logic [7:0] exp);
    M.arbitrate();
    @(posedge pclk);
    chk_val({4'h0, winner_code}, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    err_count   = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_val({4'h0, winner_code}, 8'h0f);
    chk_reg(`IDX_EH_PRIO, 8'hff);
    chk_reg(`IDX_I_OVR, 8'h00);
    chk_reg(`IDX_EH_OVR, 8'h00);
    chk_reg(`IDX_VECTOR, 8'h1e);
    wr(`IDX_VECTOR, 8'hff);
    chk_reg(`IDX_VECTOR, 8'hfe);
    chk_reg(`IDX_I_PRIO, 8'h03);
    wr(`IDX_EH_PRIO, 8'h6c);
    chk_reg(`IDX_EH_PRIO, 8'h6c);
    apb(1'b0, {2'b00, 8'h10, 2'b00}, 32'h00000000, rd, er);
    chk_val({7'h00, er}, 8'h01);
    // misaligned read and write outside the page
    apb(1'b0, {2'b00, `IDX_EH_PRIO, 2'b01}, 32'h00000000, rd, er);
    chk_val({7'h00, er}, 8'h01);
    chk_val(rd, 8'h00);
    apb(1'b1, {2'b01, `IDX_EH_PRIO, 2'b00}, 32'hffffff00, rd, er);
    chk_val({7'h00, er}, 8'h01);
    chk_reg(`IDX_EH_PRIO, 8'h6c);
    // E0 on rising, E1 on falling edge
    wr(`IDX_EH_EDGE, 8'h01);
    wr(`IDX_EVT_MASK, 8'h01);
    M.flip(0);
    M.flip(1);
    chk_reg(`IDX_EH_PEND, 8'h01);
    M.flip(1);
    chk_reg(`IDX_EH_PEND, 8'h03);
    chk_val({7'h00, cpu_req}, 8'h00);
    wr(`IDX_EH_MASK, 8'h02);
    @(posedge pclk);
    chk_val({7'h00, cpu_req}, 8'h01);
    // second rise on E0 while pending
    M.flip(0);
    M.flip(0);
    chk_reg(`IDX_EH_OVR, 8'h01);
    chk_val({7'h00, irq}, 8'h01);
    wr(`IDX_EH_OVR, 8'h00);
    chk_reg(`IDX_EH_OVR, 8'h01);
    wr(`IDX_EVT_STATUS, 8'h01);
    @(posedge pclk);
    chk_val({7'h00, irq}, 8'h00);
    wr(`IDX_EH_MASK, 8'h03);
    @(posedge pclk);
    chk_val({5'h00, cpu_req_level}, 8'h00);
    chk_win(8'h00);
    M.acknowledge();
    chk_reg(`IDX_EH_PEND, 8'h02);
    chk_reg(`IDX_EH_OVR, 8'h00);
    chk_val({5'h00, cpu_req_level}, 8'h01);
    // each pair field at its own position
    wr(`IDX_EH_MASK, 8'hff);
    wr(`IDX_EH_PEND, 8'hff);
    for (int p = 0; p < 4; p++) begin
      wr(`IDX_EH_PRIO, 8'hff ^ 8'(8'h02 << (2 * p)));
      @(posedge pclk);
      chk_val({5'h00, cpu_req_level}, 8'h02);
      chk_win(8'(2 * p));
    end
    // equal levels on E1 and F1
    wr(`IDX_EH_PRIO, 8'hf0);
    wr(`IDX_EH_PEND, 8'h0a);
    chk_win(8'h01);
    wr(`IDX_EH_PEND, 8'h0b);
    @(posedge pclk);
    chk_val({4'h0, winner_code}, 8'h01);
    chk_win(8'h00);
    M.acknowledge();
    chk_reg(`IDX_EH_PEND, 8'h0a);
    // I0 overrun with the event masked
    wr(`IDX_EH_PEND, 8'h00);
    wr(`IDX_EVT_MASK, 8'h00);
    wr(`IDX_I_EDGE, 8'h01);
    wr(`IDX_I_MASK, 8'h01);
    M.flip(8);
    M.flip(8);
    M.flip(8);
    chk_reg(`IDX_I_PEND, 8'h01);
    chk_reg(`IDX_I_OVR, 8'h01);
    chk_val({7'h00, irq}, 8'h00);
    chk_reg(`IDX_EVT_STATUS, 8'h03);
    chk_val({5'h00, cpu_req_level}, 8'h06);
    wr(`IDX_I_PRIO, 8'h01);
    @(posedge pclk);
    chk_val({5'h00, cpu_req_level}, 8'h02);
    chk_win(8'h08);
    M.acknowledge();
    chk_reg(`IDX_I_OVR, 8'h00);
    chk_reg(`IDX_I_PEND, 8'h00);
    // second reset with state loaded
    wr(`IDX_EH_MASK, 8'hff);
    wr(`IDX_EH_PEND, 8'hff);
    wr(`IDX_EH_PRIO, 8'h00);
    @(posedge pclk);
    chk_val({7'h00, cpu_req}, 8'h01);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_val({7'h00, cpu_req}, 8'h00);
    chk_val({4'h0, winner_code}, 8'h0f);
    presetn <= 1'b1;
    chk_reg(`IDX_EH_PRIO, 8'hff);
    chk_reg(`IDX_EH_PEND, 8'h00);
    chk_reg(`IDX_EH_OVR, 8'h00);
    chk_reg(`IDX_I_PRIO, 8'h03);
    report_and_stop();
  end
endmodule // tb_std_irq_channel_bank
